// ---- rtl/wpf_loader.sv ----
`timescale 1ns/10ps
`default_nettype none

module wpf_loader import wpf_pkg::*; #(
  parameter int FRAME_BYTES = WPF_FRAME_BYTES
) (
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  output logic             wake
);

  // Bus request bundle
  wpf_wb_req_t req;
  assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i};

  // Storage: command block words and received frame bytes
  logic [31:0] cmd_mem  [WPF_MAX_WORDS];
  logic [7:0]  frame    [FRAME_BYTES];

  wpf_state_t  state, next_state;
  logic [31:0] ctrl, next_ctrl;
  logic [15:0] status, next_status;
  logic [47:0] station_address, next_station_address;
  logic [4:0]  widx, next_widx;
  logic [4:0]  ridx, next_ridx;
  logic [6:0]  bidx, next_bidx;
  logic [7:0]  frame_len, next_frame_len;
  logic [31:0] sig, next_sig;
  logic [1:0]  slot, next_slot;
  logic        wake_r, next_wake;
  logic [5:0]  hit_flags, next_hit_flags;
  logic        ack, next_ack;
  logic        err, next_err;
  logic [31:0] rdat, next_rdat;
  logic        cmd_ok, next_cmd_ok;

  logic acc;
  logic wr_cmd, wr_frame;
  assign acc      = req.cyc & req.stb & ~ack & ~err;
  assign wr_cmd   = acc & req.we & (req.adr == WPF_REG_CMD) & (state == WPF_IDLE);
  assign wr_frame = acc & req.we & (req.adr == WPF_REG_FRAME) & (state == WPF_IDLE);

  // Frame header decode for the current entry
  logic [31:0] ent;
  logic        vlan;
  logic        snap;
  logic        ia_hit;
  int          sh;
  logic [15:0] word_m;
  logic [15:0] tl;
  assign ent    = cmd_mem[ridx];
  assign vlan   = ent[WPF_F_VLAN];
  assign word_m = ent[15:0];
  assign tl     = {frame[12 + (vlan ? WPF_VLAN_SHIFT : 0)],
                   frame[13 + (vlan ? WPF_VLAN_SHIFT : 0)]};
  assign snap   = (tl <= WPF_TYPE_LEN_MAX);
  assign sh     = (snap ? WPF_SNAP_SHIFT : 0) + (vlan ? WPF_VLAN_SHIFT : 0);
  assign ia_hit = ({frame[0], frame[1], frame[2], frame[3], frame[4], frame[5]}
                   == station_address);

  // Predefined filter evaluation
  logic m_nbh, m_arp, m_iat, m_ia, m_mgmt, pre_hit;
  always_comb begin
    // Word match read in wire order, like the type field
    m_nbh  = frame[0][0] & ({frame[2], frame[3]} == word_m);
    m_arp  = ({frame[12+sh], frame[13+sh]} == WPF_TYPE_ARP) &
             (frame[21+sh] == WPF_ARP_REQ) &
             ({frame[40+sh], frame[41+sh]} == word_m);
    m_iat  = ia_hit & ({frame[12+sh], frame[13+sh]} == word_m);
    m_ia   = ia_hit;
    m_mgmt = ia_hit & ~snap &
             ({frame[12+sh], frame[13+sh]} == WPF_TYPE_IP) &
             (frame[14+sh] == WPF_IP_V4H) &
             ((frame[23+sh] == WPF_PROTO_UDP) | (frame[23+sh] == WPF_PROTO_TCP)) &
             ({frame[36+sh], frame[37+sh]} == WPF_MGMT_PORT);
    // Only one word-match filter honoured, priority NEIGHBOURHOOD_FILTER_EN, ARP, type
    pre_hit = (ent[WPF_F_NBH] & m_nbh) |
              (~ent[WPF_F_NBH] & ent[WPF_F_ARP] & m_arp) |
              (~ent[WPF_F_NBH] & ~ent[WPF_F_ARP] & ent[WPF_F_IATYPE] & m_iat) |
              (ent[WPF_F_IA] & m_ia) |
              (ent[WPF_F_MGMT] & m_mgmt & ~ctrl[WPF_CTRL_EXT_MGMT]);
  end

  // Flexible mask lookup and word count
  logic [2:0]  mask_word_count;
  logic [2:0]  mwords;
  logic        mbit;
  logic [31:0] step_sig;
  logic [31:0] fbyte;
  assign mask_word_count = ent[WPF_F_MASK_WORD_COUNT_HI:WPF_F_MASK_WORD_COUNT_LO];
  always_comb begin
    case (mask_word_count)
      WPF_MASK_WORD_COUNT_1: mwords = 3'd1;
      WPF_MASK_WORD_COUNT_2: mwords = 3'd2;
      WPF_MASK_WORD_COUNT_3: mwords = 3'd3;
      WPF_MASK_WORD_COUNT_4: mwords = 3'd4;
      default:    mwords = 3'd1;
    endcase
    mbit = (bidx[6:5] < mwords[1:0] || mwords == 3'd4) &&
           cmd_mem[5'(ridx + 5'd1 + 5'(bidx[6:5]))][bidx[4:0]];
    fbyte    = 32'(frame[bidx]) << (8 * slot);
    step_sig = sig[31] ? ((sig << 1) ^ fbyte ^ WPF_CRC_POLY)
                       : ((sig << 1) ^ fbyte);
  end

  // Main sequencer and registers
  always_comb begin
    next_state           = state;
    next_ctrl            = ctrl;
    next_status          = status;
    next_station_address = station_address;
    next_widx            = widx;
    next_ridx            = ridx;
    next_bidx            = bidx;
    next_frame_len       = frame_len;
    next_sig             = sig;
    next_slot            = slot;
    next_wake            = wake_r;
    next_hit_flags       = hit_flags;
    next_ack             = 1'b0;
    next_err             = 1'b0;
    next_rdat            = 32'h0000_0000;
    next_cmd_ok          = cmd_ok;
    if (acc) begin
      next_ack = 1'b1;
      case (req.adr)
        WPF_REG_CTRL: begin
          if (req.we) next_ctrl = req.dat & 32'h0000_000E;
          next_rdat = ctrl;
        end
        WPF_REG_CMD:     next_rdat = {27'h0, widx};
        WPF_REG_STATUS:  next_rdat = {13'h0, state, status};
        WPF_REG_ADDR_LO: begin
          if (req.we) next_station_address[31:0] = req.dat;
          next_rdat = station_address[31:0];
        end
        WPF_REG_ADDR_HI: begin
          if (req.we) next_station_address[47:32] = req.dat[15:0];
          next_rdat = {16'h0, station_address[47:32]};
        end
        WPF_REG_WAKE: begin
          if (req.we && req.dat[0]) next_wake = 1'b0;  // A set below wins
          next_rdat = {25'h0, hit_flags, wake_r};
        end
        WPF_REG_FRAME: begin
          if (req.we && state == WPF_IDLE) next_frame_len = 8'(frame_len + 8'd1);
          next_rdat = {24'h0, frame_len};
        end
        WPF_REG_FLAGS: next_rdat = {31'h0, cmd_ok};
        default: begin
          next_ack = 1'b0;
          next_err = 1'b1;
        end
      endcase
      if (req.we && req.adr == WPF_REG_CMD && state == WPF_IDLE) begin
        if (widx == 5'd0) next_status = 16'h0000;
        if (widx < 5'(WPF_MAX_WORDS)) next_widx = 5'(widx + 5'd1);
      end
      if (req.we && req.adr == WPF_REG_CTRL && req.dat[WPF_CTRL_GO] && state == WPF_IDLE)
        next_state = WPF_LOAD;
      if (req.we && req.adr == WPF_REG_CTRL && req.dat[WPF_CTRL_CHECK] &&
          state == WPF_IDLE && cmd_ok) begin
        next_state = WPF_CHECK;
        next_ridx  = 5'd2;
        next_hit_flags = 6'h00;
      end
    end
    case (state)
      WPF_IDLE: ;
      WPF_LOAD: begin
        // Accept only the load opcode with last or suspend set
        next_cmd_ok = ((cmd_mem[0] & 32'h00FF_FFFF) == WPF_CMD_LOAD) &&
                      (cmd_mem[0][WPF_CMD_LAST_BIT] | cmd_mem[0][WPF_CMD_SUSP_BIT]);
        next_status = WPF_STAT_DONE_OK;
        next_widx   = 5'd0;
        next_state  = WPF_IDLE;
      end
      WPF_CHECK: begin
        if (ridx >= 5'(WPF_MAX_WORDS)) next_state = WPF_IDLE;
        else if (ent[WPF_F_FIX]) begin
          if (pre_hit) begin
            next_wake = 1'b1;
            next_hit_flags = next_hit_flags | ent[29:24];
          end
          if (ent[WPF_F_LAST]) next_state = WPF_IDLE;
          else next_ridx = 5'(ridx + 5'd1);
        end else begin
          next_bidx  = 7'd0;
          next_sig   = 32'h0000_0000;
          next_slot  = 2'd0;
          next_state = WPF_FLEX;
        end
      end
      WPF_FLEX: begin
        if (mbit && {1'b0, bidx} < frame_len) begin
          next_sig  = step_sig;
          next_slot = (slot == 2'd2) ? 2'd0 : 2'(slot + 2'd1);
        end
        if (bidx == 7'(FRAME_BYTES - 1)) begin
          next_state = WPF_DONE;
        end else begin
          next_bidx = 7'(bidx + 7'd1);
        end
      end
      WPF_DONE: begin
        if (sig[23:0] == ent[23:0]) next_wake = 1'b1;
        if (ent[WPF_F_LAST]) next_state = WPF_IDLE;
        else begin
          next_ridx  = 5'(ridx + 5'd1 + 5'(mwords));
          next_state = WPF_CHECK;
        end
      end
      default: next_state = WPF_IDLE;
    endcase
  end

  // Register update
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      state           <= WPF_IDLE;
      ctrl            <= 32'h0000_0000;
      status          <= 16'h0000;
      station_address <= 48'h0000_0000_0000;
      widx            <= 5'd0;
      ridx            <= 5'd0;
      bidx            <= 7'd0;
      frame_len       <= 8'h00;
      sig             <= 32'h0000_0000;
      slot            <= 2'd0;
      wake_r          <= 1'b0;
      hit_flags       <= 6'h00;
      ack             <= 1'b0;
      err             <= 1'b0;
      rdat            <= 32'h0000_0000;
      cmd_ok          <= 1'b0;
    end else begin
      state           <= next_state;
      ctrl            <= next_ctrl;
      status          <= next_status;
      station_address <= next_station_address;
      widx            <= next_widx;
      ridx            <= next_ridx;
      bidx            <= next_bidx;
      frame_len       <= next_frame_len;
      sig             <= next_sig;
      slot            <= next_slot;
      wake_r          <= next_wake;
      hit_flags       <= next_hit_flags;
      ack             <= next_ack;
      err             <= next_err;
      rdat            <= next_rdat;
      cmd_ok          <= next_cmd_ok;
    end
  end

  // Memory writes, no reset needed
  always_ff @(posedge mclk) begin
    if (wr_cmd && widx < 5'(WPF_MAX_WORDS)) cmd_mem[widx] <= req.dat;
    if (wr_frame && frame_len < 8'(FRAME_BYTES)) frame[7'(frame_len)] <= req.dat[7:0];
  end

  assign wb_dat_o = rdat;
  assign wb_ack_o = ack;
  assign wb_err_o = err;
  assign wake     = wake_r;

endmodule

`default_nettype wire

// ---- rtl/wpf_pkg.sv ----
package wpf_pkg;

  // Command field of the filter-load command word
  localparam logic [31:0] WPF_CMD_LOAD      = 32'h0008_0000;
  localparam logic [31:0] WPF_CMD_OP_MASK   = 32'h0007_0000;
  localparam int          WPF_CMD_LAST_BIT  = 31;
  localparam int          WPF_CMD_SUSP_BIT  = 30;
  localparam logic [15:0] WPF_STAT_DONE_OK  = 16'hA000;
  localparam int          WPF_MAX_WORDS     = 18;

  // Filter entry field positions
  localparam int WPF_F_LAST   = 31;
  localparam int WPF_F_FIX    = 30;
  localparam int WPF_F_VLAN   = 29;
  localparam int WPF_F_NBH    = 28;
  localparam int WPF_F_ARP    = 27;
  localparam int WPF_F_IATYPE = 26;
  localparam int WPF_F_IA     = 25;
  localparam int WPF_F_MGMT   = 24;
  localparam int WPF_F_MASK_WORD_COUNT_HI = 29;
  localparam int WPF_F_MASK_WORD_COUNT_LO = 27;

  // Mask length codes
  localparam logic [2:0] WPF_MASK_WORD_COUNT_1 = 3'h0;
  localparam logic [2:0] WPF_MASK_WORD_COUNT_2 = 3'h1;
  localparam logic [2:0] WPF_MASK_WORD_COUNT_3 = 3'h3;
  localparam logic [2:0] WPF_MASK_WORD_COUNT_4 = 3'h7;

  // Frame constants
  localparam int          WPF_FRAME_BYTES = 128;
  localparam int          WPF_SNAP_SHIFT  = 8;
  localparam int          WPF_VLAN_SHIFT  = 4;
  localparam logic [15:0] WPF_TYPE_ARP    = 16'h0806;
  localparam logic [15:0] WPF_TYPE_IP     = 16'h0800;
  localparam logic [15:0] WPF_TYPE_LEN_MAX = 16'h05DC;
  localparam logic [7:0]  WPF_ARP_REQ     = 8'h01;
  localparam logic [7:0]  WPF_IP_V4H      = 8'h45;
  localparam logic [7:0]  WPF_PROTO_UDP   = 8'h11;
  localparam logic [7:0]  WPF_PROTO_TCP   = 8'h04;
  localparam logic [15:0] WPF_MGMT_PORT   = 16'h026F;
  localparam logic [31:0] WPF_CRC_POLY    = 32'h04C1_1DB7;

  // Register offsets (byte addresses)
  localparam logic [7:0] WPF_REG_CTRL   = 8'h00;
  localparam logic [7:0] WPF_REG_CMD    = 8'h04;
  localparam logic [7:0] WPF_REG_STATUS = 8'h08;
  localparam logic [7:0] WPF_REG_ADDR_LO = 8'h0C;
  localparam logic [7:0] WPF_REG_ADDR_HI = 8'h10;
  localparam logic [7:0] WPF_REG_WAKE   = 8'h14;
  localparam logic [7:0] WPF_REG_FRAME  = 8'h18;
  localparam logic [7:0] WPF_REG_FLAGS  = 8'h1C;

  // Control register bit positions
  localparam int WPF_CTRL_GO       = 0;
  localparam int WPF_CTRL_MAGIC_EN = 1;
  localparam int WPF_CTRL_EXT_MGMT = 2;
  localparam int WPF_CTRL_CHECK    = 3;

  typedef enum logic [2:0] {
    WPF_IDLE  = 3'b000,
    WPF_LOAD  = 3'b001,
    WPF_CHECK = 3'b010,
    WPF_FLEX  = 3'b011,
    WPF_DONE  = 3'b100
  } wpf_state_t;

  // Wishbone request bundle
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } wpf_wb_req_t;

endpackage

// ---- verification/tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb import wpf_pkg::*; ;
  logic        mclk;
  logic        nrst;
  wpf_wb_req_t req;
  logic [31:0] rdat;
  logic        ack;
  logic        err;
  logic        wake;
  logic [7:0]  frm [64];
  int          fail_count;
  int          cmp_count;
  logic [31:0] chk_ctl   = 32'h0000_0008;
  logic [31:0] mask_word = 32'h0000_0000;
  wpf_loader #(.FRAME_BYTES(WPF_FRAME_BYTES)) wpf_loader_inst (
    .mclk(mclk), .nrst(nrst), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb), .wb_we_i(req.we),
    .wb_sel_i(req.sel), .wb_adr_i(req.adr), .wb_dat_i(req.dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .wake(wake));
  wpf_host_model wpf_host_model_inst (.mclk(mclk), .req(req), .ack(ack), .err(err), .dat(rdat));
  // Clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;
  task automatic bad(input string m);
    fail_count++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    wpf_host_model_inst.xfer(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
    wpf_host_model_inst.xfer(1'b0, a, 32'h0000_0000, q, e);
    cmp_count++;
  endtask
  task automatic do_reset();
    @(posedge mclk);
    nrst <= 1'b0;
    repeat (6) @(posedge mclk);
    nrst <= 1'b1;
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    logic        e;
    int          n;
    q = 32'hFFFF_FFFF;
    for (n = 0; n < 100 && q[18:16] !== 3'h0; n++) wpf_host_model_inst.xfer(1'b0, WPF_REG_STATUS, 32'h0000_0000, q, e);
    if (q[18:16] !== 3'h0) bad("block stays busy");
  endtask
  // Load one block, process it, return the valid flag
  task automatic go_flags(input logic [31:0] op, output logic [31:0] q);
    logic e;
    wpf_host_model_inst.send_cmd(op, 32'hC200_0000);
    wr(WPF_REG_CTRL, 32'h0000_0001);
    wait_idle();
    rd(WPF_REG_FLAGS, q, e);
  endtask
  // Frame addressed to the station, rest zero
  task automatic set_base();
    foreach (frm[i]) frm[i] = 8'h00;
    {frm[0], frm[1], frm[2], frm[3], frm[4], frm[5]} = 48'h0212_3456_789A;
  endtask
  // Load one entry, send the frame, return the wake flag
  task automatic run(input logic [31:0] entry, input int len, output logic w);
    logic [31:0] q;
    logic        e;
    do_reset();
    wr(WPF_REG_ADDR_LO, 32'h3456_789A);
    wr(WPF_REG_ADDR_HI, 32'h0000_0212);
    wpf_host_model_inst.send_cmd(32'h8008_0000, entry);
    if (mask_word !== 32'h0000_0000) wr(WPF_REG_CMD, mask_word);
    wr(WPF_REG_CTRL, 32'h0000_0001);
    wait_idle();
    for (int i = 0; i < len; i++) wr(WPF_REG_FRAME, {24'h00_0000, frm[i]});
    wr(WPF_REG_CTRL, chk_ctl);
    wait_idle();
    rd(WPF_REG_WAKE, q, e);
    w = q[0];
  endtask
  task automatic t_load();
    logic [31:0] q;
    logic        e;
    do_reset();
    go_flags(32'h8008_0000, q);
    if (q[0] !== 1'b1) bad("load command not valid");
    rd(WPF_REG_STATUS, q, e);
    if (q[15:0] !== WPF_STAT_DONE_OK) bad("status not done");
    rd(8'h20, q, e);
    if (e !== 1'b1) bad("unmapped read not refused");
    // No reset between blocks, so the valid flag must fall
    go_flags(32'h8001_0000, q);
    if (q[0] !== 1'b0) bad("wrong opcode accepted");
    go_flags(32'h4008_0000, q);
    if (q[0] !== 1'b1) bad("suspend flag refused");
    go_flags(32'h0008_0000, q);
    if (q[0] !== 1'b0) bad("no last or suspend accepted");
  endtask
  task automatic t_addr();
    logic [31:0] q;
    logic        e;
    logic        w;
    set_base();
    run(32'hC200_0000, 14, w);
    if (w !== 1'b1) bad("address match missed");
    wr(WPF_REG_WAKE, 32'h0000_0001);
    rd(WPF_REG_WAKE, q, e);
    if (q[0] !== 1'b0) bad("wake not cleared");
    if (q[6:1] !== 6'h02) bad("hit flags wrong");
    frm[5] = 8'h9B;
    run(32'hC200_0000, 14, w);
    if (w !== 1'b0) bad("foreign address woke");
  endtask
  task automatic t_arp();
    logic w;
    set_base();
    {frm[12], frm[13], frm[21], frm[40], frm[41]} = 40'h08_0601_3F3D;
    run(32'hC800_3F3D, 42, w);
    if (w !== 1'b1) bad("arp request missed");
    run(32'hC800_3F3E, 42, w);
    if (w !== 1'b0) bad("arp word mismatch woke");
    frm[21] = 8'h02;
    run(32'hC800_3F3D, 42, w);
    if (w !== 1'b0) bad("arp reply woke");
    frm[21] = 8'h01;
    for (int i = 63; i >= 16; i--) frm[i] = frm[i-4];
    {frm[12], frm[13], frm[14], frm[15]} = 32'h8100_0001;
    run(32'hE800_3F3D, 46, w);
    if (w !== 1'b1) bad("tagged arp missed");
    run(32'hC800_3F3D, 46, w);
    if (w !== 1'b0) bad("tag not skipped only on flag");
  endtask
  // Neighbourhood, address with type over SNAP, management port
  task automatic t_word();
    logic w;
    set_base();
    run(32'hD000_3456, 14, w);
    if (w !== 1'b0) bad("even first byte woke");
    frm[0] = 8'h03;
    run(32'hD000_3456, 14, w);
    if (w !== 1'b1) bad("neighbourhood missed");
    set_base();
    {frm[12], frm[13], frm[20], frm[21]} = 32'h0040_0800;
    run(32'hC400_0800, 22, w);
    if (w !== 1'b1) bad("snap type match missed");
    run(32'hC400_0806, 22, w);
    if (w !== 1'b0) bad("snap type mismatch woke");
    set_base();
    {frm[12], frm[13], frm[14], frm[23], frm[36], frm[37]} = 48'h0800_4511_026F;
    run(32'hC100_0000, 38, w);
    if (w !== 1'b1) bad("management port missed");
    chk_ctl = 32'h0000_000C;
    run(32'hC100_0000, 38, w);
    chk_ctl = 32'h0000_0008;
    if (w !== 1'b0) bad("management wake not masked");
  endtask
  // Flexible filter on bytes 0 and 1: 02 then 12 give signature 00_1204
  task automatic t_flex();
    logic w;
    set_base();
    mask_word = 32'h0000_0003;
    run(32'h8000_1204, 14, w);
    if (w !== 1'b1) bad("flexible signature missed");
    run(32'h8000_1205, 14, w);
    mask_word = 32'h0000_0000;
    if (w !== 1'b0) bad("flexible mismatch woke");
  endtask
  task automatic give_verdict();
    $display("mismatches %0d comparisons %0d", fail_count, cmp_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400us;
    bad("timeout");
    give_verdict();
  end
  // Main sequence
  initial begin
    nrst = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    t_load();
    t_addr();
    t_arp();
    t_word();
    t_flex();
    give_verdict();
  end
endmodule
`default_nettype wire

// ---- verification/wpf_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module wpf_host_model import wpf_pkg::*; (
  input  wire logic        mclk,
  output var wpf_wb_req_t  req,
  input  wire logic        ack,
  input  wire logic        err,
  input  wire logic [31:0] dat
);
  initial req = '0;
  // One classic cycle, held until ack or err
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    @(posedge mclk);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
    @(posedge mclk);
    // Ends on ack or err; if neither comes, only the bench watchdog ends this wait
    while (ack !== 1'b1 && err !== 1'b1) @(posedge mclk);
    q = dat;
    e = err;
    // Released lines show inverted values
    req <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: 4'h0, adr: ~a, dat: ~d};
  endtask
  // Three-word command block
  task automatic send_cmd(input logic [31:0] op, input logic [31:0] entry);
    logic [31:0] q;
    logic        e;
    xfer(1'b1, WPF_REG_CMD, op, q, e);
    xfer(1'b1, WPF_REG_CMD, 32'hFFFF_FFFF, q, e);
    xfer(1'b1, WPF_REG_CMD, entry, q, e);
  endtask
endmodule
`default_nettype wire

// ---- verification/wpf_loader_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module wpf_loader_assertions import wpf_pkg::*; #(
  parameter int FRAME_BYTES = WPF_FRAME_BYTES
) (
  input wire logic        mclk,
  input wire logic        nrst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        wb_err_o,
  input wire logic        wake
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  // Request taken, address decode and wake clear write
  wire take   = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire mapped = (wb_adr_i[1:0] == 2'b00) && (wb_adr_i <= WPF_REG_FLAGS);
  wire wclr   = take && wb_we_i && (wb_adr_i == WPF_REG_WAKE) && wb_dat_i[0];
  // Steps of an answer, of a load start and of a status read
  sequence s_answer;
    (wb_ack_o ^ wb_err_o) ##1 (!wb_ack_o && !wb_err_o);
  endsequence
  sequence s_go;
    take && wb_we_i && (wb_adr_i == WPF_REG_CTRL) && wb_dat_i[WPF_CTRL_GO];
  endsequence
  sequence s_stat_rd;
    take && !wb_we_i && (wb_adr_i == WPF_REG_STATUS);
  endsequence
  a_answer_once: assert property (take |=> s_answer)
    else $error("answer is not a single pulse");
  a_err_unmapped: assert property (take && !mapped |=> wb_err_o && !wb_ack_o)
    else $error("unmapped access not refused");
  a_ack_mapped: assert property (take && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped access not acknowledged");
  a_no_spurious: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o && !wb_err_o)
    else $error("answer without request");
  a_reset_quiet: assert property ($rose(nrst) |-> !wb_ack_o && !wb_err_o && !wake)
    else $error("outputs not quiet after reset");
  a_wake_clear: assert property (wclr |-> ##[1:2] !wake)
    else $error("wake not cleared");
  a_wake_sticky: assert property (wake && !wclr |=> wake)
    else $error("wake dropped by itself");
  a_status_done: assert property (s_go ##[2:12] s_stat_rd |=> wb_dat_o[15:0] == WPF_STAT_DONE_OK)
    else $error("status not done after load");
endmodule
bind wpf_loader wpf_loader_assertions #(.FRAME_BYTES(FRAME_BYTES)) wpf_loader_assertions_inst (
  .mclk(mclk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .wake(wake));
`default_nettype wire
